// >>> logic/smr_consts.svh
/*
 * smr_consts.svh: register offsets, field positions, reset values and
 * timing counts for the sdram mux / refresh / card strobe block.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH

// apb byte offsets, one aligned word per register
`define SMR_OFS_MEM_CTL 8'h00
`define SMR_OFS_CARD_CTL 8'h04
`define SMR_OFS_WAIT_TWO 8'h08
`define SMR_OFS_STATUS 8'h0c

// memory_control fields
`define SMR_MC_MUX_HI 6
`define SMR_MC_MUX_LO 3
`define SMR_MC_REFRESH_ON 2
`define SMR_MC_REFRESH_KIND 1
`define SMR_MC_RESET 16'h0000

// card_strobe_control fields
`define SMR_CC_AREA6_WAIT_HI 15
`define SMR_CC_AREA5_WAIT_HI 14
`define SMR_CC_RSVD_MASK 16'hcfff
`define SMR_CC_RESET 16'h0000

// wait_control_two: area5 low wait bits [2:0], area6 [5:3]
`define SMR_W2_AREA5_LO 0
`define SMR_W2_AREA6_LO 3
`define SMR_W2_RESET 16'h003f

// row address multiplex codes
`define SMR_MUX_4MX16 4'hd
`define SMR_MUX_8MX16 4'he
`define SMR_MUX_1MX16 4'h4
`define SMR_MUX_2MX8 4'h5
`define SMR_MUX_512KX32 4'h7

// one bus state is two clk cycles, so a half state is one cycle
`define SMR_CLKS_PER_STATE 2
`define SMR_BURST_STATES_CODE0 2

`endif

// >>> logic/smr_pkg.sv
/*
 * smr_pkg: types shared by the block and its bench.
 * Assumes smr_consts.svh supplies the numeric constants.
 */
package smr_pkg;

   typedef enum logic [1:0] {
      SMR_RF_IDLE,
      SMR_RF_SELF
   } smr_refresh_state_t;

   typedef enum logic [1:0] {
      SMR_CD_IDLE,
      SMR_CD_SETUP,
      SMR_CD_STROBE,
      SMR_CD_HOLD
   } smr_card_state_t;

   // one card access request, valid for one cycle
   typedef struct packed {
      logic valid;
      logic area6;
      logic write;
      logic [3:0] beats;
   } smr_card_req_t;

   // card strobes oe_b and we_b active low, busy and done active high
   typedef struct packed {
      logic oe_b;
      logic we_b;
      logic busy;
      logic done;
   } smr_card_strobe_t;

endpackage

// >>> logic/smr_ctrl.sv
/*
 * smr_ctrl: sdram row address multiplexer, refresh sequencing and the
 * card strobe timing for areas 5 and 6, with an apb register slave.
 * Assumes all inputs synchronous to clk_in; the refresh timer lives
 * outside and delivers refresh_req_in pulses; rst_b_in is power-on.
 */
// How it works
// - mux code 4Mx16 starts row at A10
// - mux code 8Mx16 starts row at A11
// - mux code 1Mx16 starts row at A9
// - mux code 2Mx8/2Mx16 starts row at A10
// - mux code 512kx32 starts row at A9
// - refresh off by default; timer becomes interval
// - auto refresh on each timer request
// - refresh waits for running bus cycle
// - self refresh entered after bus cycle
// - requests dropped while in self refresh
// - memory control bit zero reads zero
// - card register cleared only by power-on
// - strobe width follows area wait code
// - wait code table, wait pin ignored on code0 first beat
// - burst beats take wait plus one, code0 two states
// - area 5 uses the same mapping
// - card register bits 13:12 read zero
// - assert delay is code plus half
// - address hold is code plus half
`timescale 1ns/100ps
`include "smr_consts.svh"

module smr_ctrl #(
   parameter int ADDR_W = 26,
   parameter int ROW_W = 14
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic manual_rst_b_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic row_phase_in,
   output logic [ROW_W-1:0] sdram_addr_out,
   input wire logic bus_busy_in,
   input wire logic refresh_req_in,
   output logic refresh_cmd_out,
   output logic self_refresh_out,
   input wire smr_pkg::smr_card_req_t card_req_in,
   input wire logic card_wait_b_in,
   output smr_pkg::smr_card_strobe_t card_out
);
   import smr_pkg::*;

   logic [15:1] mem_ctl;
   logic [15:0] card_ctl;
   logic [15:0] wait_two;
   logic interval_flag;
   logic refresh_pending;
   smr_refresh_state_t rf_state;
   smr_card_state_t cd_state;
   logic [7:0] cd_cnt;
   logic [3:0] cd_beats;
   logic cd_first;
   logic cd_area6;
   logic cd_write;
   logic [3:0] cd_code;
   // first-cycle wait states for a 4-bit wait code
   function automatic logic [5:0] wait_states(input logic [3:0] code);
      case (code)
         4'h0: wait_states = 6'h00;
         4'h1: wait_states = 6'h01;
         4'h2: wait_states = 6'h02;
         4'h3: wait_states = 6'h03;
         4'h4: wait_states = 6'h04;
         4'h5: wait_states = 6'h06;
         4'h6: wait_states = 6'h08;
         4'h7: wait_states = 6'h0a;
         4'h8: wait_states = 6'h0c;
         4'h9: wait_states = 6'h0e;
         4'ha: wait_states = 6'h12;
         4'hb: wait_states = 6'h16;
         4'hc: wait_states = 6'h1a;
         4'hd: wait_states = 6'h1e;
         4'he: wait_states = 6'h22;
         default: wait_states = 6'h26;
      endcase
   endfunction
   // row start bit for a mux code, zero for codes that are not defined
   function automatic logic [4:0] row_start(input logic [3:0] code);
      case (code)
         `SMR_MUX_4MX16: row_start = 5'h0a;
         `SMR_MUX_8MX16: row_start = 5'h0b;
         `SMR_MUX_1MX16: row_start = 5'h09;
         `SMR_MUX_2MX8: row_start = 5'h0a;
         `SMR_MUX_512KX32: row_start = 5'h09;
         default: row_start = 5'h00;
      endcase
   endfunction
   // area code: card register high bit over the three low wait bits
   function automatic logic [3:0] area_code(input logic a6,
                                            input logic [15:0] cc,
                                            input logic [15:0] w2);
      if (a6) begin
         area_code = {cc[`SMR_CC_AREA6_WAIT_HI],
                      w2[`SMR_W2_AREA6_LO +: 3]};
      end else begin
         area_code = {cc[`SMR_CC_AREA5_WAIT_HI],
                      w2[`SMR_W2_AREA5_LO +: 3]};
      end
   endfunction
   logic [3:0] mux_code;
   logic [4:0] start_bit;
   logic mux_ok;
   logic refresh_on;
   logic refresh_kind;
   assign mux_code = mem_ctl[`SMR_MC_MUX_HI:`SMR_MC_MUX_LO];
   assign start_bit = row_start(mux_code);
   assign mux_ok = (start_bit != 5'h00);
   assign refresh_on = mem_ctl[`SMR_MC_REFRESH_ON];
   assign refresh_kind = mem_ctl[`SMR_MC_REFRESH_KIND];
   // apb decode; zero wait states, so pready is always high
   logic wr_en, setup, mapped;
   assign setup = psel_in & ~penable_in;
   assign mapped = (paddr_in[1:0] == 2'b00) & (paddr_in <= `SMR_OFS_STATUS);
   assign wr_en = psel_in & penable_in & pwrite_in;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in & penable_in & ~mapped;
   // configuration registers: power-on reset only, manual reset keeps them
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mem_ctl <= 15'(`SMR_MC_RESET >> 1);
         card_ctl <= `SMR_CC_RESET;
         wait_two <= `SMR_W2_RESET;
      end else if (wr_en) begin
         case (paddr_in)
            `SMR_OFS_MEM_CTL: mem_ctl <= pwdata_in[15:1];
            `SMR_OFS_CARD_CTL: begin
               card_ctl <= pwdata_in[15:0] & `SMR_CC_RSVD_MASK;
            end
            `SMR_OFS_WAIT_TWO: wait_two <= {10'h000, pwdata_in[5:0]};
            default: ;
         endcase
      end
   end
   // read data sampled in the setup phase, stable through access
   logic [15:0] status;
   assign status = {11'h000, ~mux_ok, cd_state != SMR_CD_IDLE,
                    interval_flag, refresh_pending, self_refresh_out};
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (setup) begin
         case (paddr_in)
            `SMR_OFS_MEM_CTL: prdata_out <= {16'h0000, mem_ctl, 1'b0};
            `SMR_OFS_CARD_CTL: prdata_out <= {16'h0000, card_ctl};
            `SMR_OFS_WAIT_TWO: prdata_out <= {16'h0000, wait_two};
            `SMR_OFS_STATUS: prdata_out <= {16'h0000, status};
            default: prdata_out <= 32'h0000_0000;
         endcase
      end
   end
   // interval flag: timer requests while refresh is off; set beats clear
   logic interval_clr;
   assign interval_clr = wr_en & (paddr_in == `SMR_OFS_STATUS) &
                         pwdata_in[2];
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         interval_flag <= 1'b0;
      end else if (refresh_req_in && !refresh_on) begin
         interval_flag <= 1'b1;
      end else if (interval_clr) begin
         interval_flag <= 1'b0;
      end
   end
   // row/column address out; undefined mux codes pass the address through
   logic [ADDR_W-1:0] shifted;
   assign shifted = addr_in >> (start_bit - 5'h01);
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sdram_addr_out <= '0;
      end else if (row_phase_in && mux_ok) begin
         sdram_addr_out <= shifted[ROW_W-1:0];
      end else begin
         sdram_addr_out <= addr_in[ROW_W-1:0];
      end
   end
   // refresh sequencing; self refresh swallows every request
   logic issue;
   assign issue = refresh_pending & ~bus_busy_in & refresh_on &
                  ~refresh_kind & (rf_state == SMR_RF_IDLE);
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         refresh_pending <= 1'b0;
      end else if (!manual_rst_b_in || !refresh_on || refresh_kind) begin
         refresh_pending <= 1'b0;
      end else if (refresh_req_in) begin
         refresh_pending <= 1'b1;
      end else if (issue) begin
         refresh_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         refresh_cmd_out <= 1'b0;
      end else begin
         refresh_cmd_out <= issue & manual_rst_b_in;
      end
   end
   // self refresh entered only between bus cycles, left on mode change
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rf_state <= SMR_RF_IDLE;
      end else if (!manual_rst_b_in) begin
         rf_state <= SMR_RF_IDLE;
      end else begin
         case (rf_state)
            SMR_RF_IDLE: begin
               if (refresh_on && refresh_kind && !bus_busy_in) begin
                  rf_state <= SMR_RF_SELF;
               end
            end
            SMR_RF_SELF: begin
               if (!refresh_on || !refresh_kind) begin
                  rf_state <= SMR_RF_IDLE;
               end
            end
            default: rf_state <= SMR_RF_IDLE;
         endcase
      end
   end
   assign self_refresh_out = (rf_state == SMR_RF_SELF);
   // card access timing; a half state is one clk, a state is two
   logic [3:0] req_code;
   logic [7:0] first_cnt, burst_cnt;
   logic [2:0] ted, teh;
   logic wait_hold;
   assign req_code = area_code(card_req_in.area6, card_ctl, wait_two);
   assign first_cnt = 8'((wait_states(cd_code) + 6'h01) *
                         `SMR_CLKS_PER_STATE);
   assign burst_cnt = (cd_code == 4'h0) ?
                      8'(`SMR_BURST_STATES_CODE0 * `SMR_CLKS_PER_STATE) :
                      first_cnt;
   assign ted = cd_area6 ? {card_ctl[10], card_ctl[5:4]} :
                           {card_ctl[11], card_ctl[7:6]};
   assign teh = cd_area6 ? {card_ctl[8], card_ctl[1:0]} :
                           {card_ctl[9], card_ctl[3:2]};
   // wait pin honoured except on the first beat of code zero
   assign wait_hold = ~card_wait_b_in &
                      ~(cd_first && cd_code == 4'h0);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cd_state <= SMR_CD_IDLE;
         cd_cnt <= 8'h00;
         cd_beats <= 4'h0;
         cd_first <= 1'b0;
         cd_area6 <= 1'b0;
         cd_write <= 1'b0;
         cd_code <= 4'h0;
      end else if (!manual_rst_b_in) begin
         cd_state <= SMR_CD_IDLE;
         cd_cnt <= 8'h00;
      end else begin
         case (cd_state)
            SMR_CD_IDLE: begin
               if (card_req_in.valid) begin
                  cd_area6 <= card_req_in.area6;
                  cd_write <= card_req_in.write;
                  cd_code <= req_code;
                  cd_beats <= (card_req_in.beats == 4'h0) ? 4'h1 :
                              card_req_in.beats;
                  cd_first <= 1'b1;
                  cd_cnt <= 8'h00;
                  cd_state <= SMR_CD_SETUP;
               end
            end
            SMR_CD_SETUP: begin
               // two ticks per code step plus the half state
               if (cd_cnt == {4'h0, ted, 1'b0}) begin
                  cd_cnt <= first_cnt;
                  cd_state <= SMR_CD_STROBE;
               end else begin
                  cd_cnt <= cd_cnt + 8'h01;
               end
            end
            SMR_CD_STROBE: begin
               if (cd_cnt > 8'h01) begin
                  cd_cnt <= cd_cnt - 8'h01;
               end else if (!wait_hold) begin
                  if (cd_beats > 4'h1) begin
                     cd_beats <= cd_beats - 4'h1;
                     cd_first <= 1'b0;
                     cd_cnt <= burst_cnt;
                  end else begin
                     cd_cnt <= 8'h00;
                     cd_state <= SMR_CD_HOLD;
                  end
               end
            end
            SMR_CD_HOLD: begin
               if (cd_cnt == {4'h0, teh, 1'b0}) begin
                  cd_state <= SMR_CD_IDLE;
               end else begin
                  cd_cnt <= cd_cnt + 8'h01;
               end
            end
            default: cd_state <= SMR_CD_IDLE;
         endcase
      end
   end
   // strobes registered so they carry no decode glitches
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         card_out <= '{oe_b: 1'b1, we_b: 1'b1, busy: 1'b0, done: 1'b0};
      end else begin
         card_out.oe_b <= ~(cd_state == SMR_CD_STROBE && !cd_write);
         card_out.we_b <= ~(cd_state == SMR_CD_STROBE && cd_write);
         card_out.busy <= (cd_state != SMR_CD_IDLE);
         card_out.done <= (cd_state == SMR_CD_HOLD) && manual_rst_b_in &&
                          (cd_cnt == {4'h0, teh, 1'b0});
      end
   end
   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   logic strobe_on;
   assign strobe_on = (cd_state == SMR_CD_STROBE);
   a_mux_row_4m: assert property (
      row_phase_in && mux_code == `SMR_MUX_4MX16 |=>
         sdram_addr_out[1] == $past(addr_in[10]))
      else $error("row bit A1 wrong for 4M code");
   a_mux_row_8m: assert property (
      row_phase_in && mux_code == `SMR_MUX_8MX16 |=>
         sdram_addr_out[1] == $past(addr_in[11]))
      else $error("row bit A1 wrong for 8M code");
   a_mux_row_1m: assert property (
      row_phase_in && mux_code == `SMR_MUX_1MX16 |=>
         sdram_addr_out[1] == $past(addr_in[9]))
      else $error("row bit A1 wrong for 1M code");
   a_mux_row_2m: assert property (
      row_phase_in && mux_code == `SMR_MUX_2MX8 |=>
         sdram_addr_out[1] == $past(addr_in[10]))
      else $error("row bit A1 wrong for 2M code");
   a_mux_row_512k: assert property (
      row_phase_in && mux_code == `SMR_MUX_512KX32 |=>
         sdram_addr_out[1] == $past(addr_in[9]))
      else $error("row bit A1 wrong for 512k code");
   a_refresh_off_quiet: assert property (
      !refresh_on |=> !refresh_cmd_out)
      else $error("refresh command while refresh disabled");
   a_refresh_waits_bus: assert property (
      refresh_cmd_out |-> !$past(bus_busy_in))
      else $error("refresh issued during bus cycle");
   a_auto_refresh_issue: assert property (
      refresh_pending && !bus_busy_in && !self_refresh_out && refresh_on &&
      !refresh_kind && manual_rst_b_in |=> refresh_cmd_out)
      else $error("pending refresh not issued");
   a_self_entry_idle: assert property (
      $rose(self_refresh_out) |-> !$past(bus_busy_in))
      else $error("self refresh entered mid cycle");
   a_self_no_cmd: assert property (
      self_refresh_out |=> !refresh_cmd_out ##1 !refresh_cmd_out)
      else $error("refresh command in self refresh");
   a_mc_bit0_zero: assert property (
      psel_in && penable_in && !pwrite_in &&
      paddr_in == `SMR_OFS_MEM_CTL |-> prdata_out[0] == 1'b0)
      else $error("memory control bit 0 not zero");
   a_cc_rsvd_zero: assert property (
      card_ctl[13:12] == 2'b00)
      else $error("card control reserved bits set");
   a_strobe_width: assert property (
      $rose(strobe_on) && cd_code == 4'h1 && cd_beats == 4'h1 |->
         strobe_on [*4] ##1 (strobe_on == !$past(card_wait_b_in)))
      else $error("strobe shorter than wait code");
   a_assert_delay: assert property (
      $rose(cd_state == SMR_CD_SETUP) && ted == 3'h0 |=> strobe_on)
      else $error("assert delay wrong for code zero");
   a_hold_delay: assert property (
      $fell(strobe_on) && teh == 3'h3 && manual_rst_b_in |->
         (cd_state == SMR_CD_HOLD) [*7] ##1 cd_state == SMR_CD_IDLE)
      else $error("address hold wrong for code three");
   c_auto_refresh: cover property (refresh_cmd_out);
   c_self_refresh: cover property ($rose(self_refresh_out));
   c_card_burst: cover property (strobe_on && !cd_first);
   c_card_done: cover property (card_out.done);
endmodule

// >>> tb/smr_card_model.sv
/*
 * smr_card_model: card device on the far side, answering strobes
 * with its WAIT pin. Assumes active-low strobes from smr_ctrl and a
 * stall length set by the bench; WAIT rests at its pull-up level.
 */
`timescale 1ns/100ps
module smr_card_model (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire smr_pkg::smr_card_strobe_t card_in,
   input wire logic [7:0] stall_in,
   output logic wait_b_out
);
   import smr_pkg::*;
   logic [7:0] cnt;
   logic act;
   // either strobe low means the card is being accessed
   assign act = !card_in.oe_b || !card_in.we_b;
   // slow card: wait held low for the first stall_in strobe cycles
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt <= 8'h00;
         wait_b_out <= 1'b1;
      end else begin
         cnt <= act ? cnt + 8'h01 : 8'h00;
         wait_b_out <= !(act && cnt < stall_in); // idle: pull-up
      end
   end
endmodule

// >>> tb/sdram_mux_refresh_card_wait_test.sv
/*
 * sdram_mux_refresh_card_wait_test: apb-driven bench for smr_ctrl.
 * Assumes the zero-wait apb slave and smr_card_model on the card side.
 */
`timescale 1ns/100ps
`include "smr_consts.svh"
module sdram_mux_refresh_card_wait_test;
   import smr_pkg::*;
   logic clk_in, rst_b_in, mrst_b, psel, pen, pwr, busy, rreq, rowph;
   logic pready, pslverr, rcmd, selfr, wait_b, err;
   logic [7:0] paddr, stall;
   logic [31:0] pwdata, prdata, q;
   logic [25:0] addr;
   logic [13:0] sdaddr;
   smr_card_req_t creq;
   smr_card_strobe_t cout;
   int num_errors, checks_done, s, w, h, n, dn;
   int waits[16] = '{0, 1, 2, 3, 4, 6, 8, 10, 12, 14, 18, 22, 26, 30, 34, 38};
   int st[5] = '{10, 11, 9, 10, 9};
   logic [3:0] mux[5] = '{`SMR_MUX_4MX16, `SMR_MUX_8MX16, `SMR_MUX_1MX16,
      `SMR_MUX_2MX8, `SMR_MUX_512KX32};

   smr_ctrl #(.ADDR_W(26), .ROW_W(14)) u_dut (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .manual_rst_b_in(mrst_b), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .addr_in(addr), .row_phase_in(rowph),
      .sdram_addr_out(sdaddr), .bus_busy_in(busy), .refresh_req_in(rreq),
      .refresh_cmd_out(rcmd), .self_refresh_out(selfr),
      .card_req_in(creq), .card_wait_b_in(wait_b), .card_out(cout));
   smr_card_model u_card (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .card_in(cout), .stall_in(stall), .wait_b_out(wait_b));

   // 125 mhz
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (num_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk_in);
   endtask
   // one apb transfer; entered just after a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      pen <= 1'b0;
      @(posedge clk_in);
      pen <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk_in);
   endtask
   task pulse_req;
      rreq <= 1'b1;
      @(posedge clk_in);
      rreq <= 1'b0;
   endtask
   // n = cycles until a refresh command, 20 if none came
   task wait_cmd;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (rcmd !== 1'b1 && n < 20);
      @(posedge clk_in);
   endtask
   function logic strb(input logic wr);
      return wr ? cout.we_b : cout.oe_b;
   endfunction
   // card access: s setup, w strobe, h hold cycles, dn done pulses
   task card_op(input logic a6, input logic wr, input logic [3:0] bt);
      creq <= '{1'b1, a6, wr, bt};
      @(posedge clk_in);
      creq.valid <= 1'b0;
      s = 0;
      w = 0;
      h = 0;
      dn = 0;
      @(negedge clk_in);
      while (strb(wr) === 1'b1 && s < 200) begin
         s++;
         @(negedge clk_in);
      end
      while (strb(wr) === 1'b0 && w < 200) begin
         w++;
         @(negedge clk_in);
      end
      while (cout.busy !== 1'b0 && h < 200) begin
         h++;
         dn += (cout.done === 1'b1);
         @(negedge clk_in);
      end
      cyc(3);
   endtask

   // main sequence
   initial begin
      {rst_b_in, psel, pen, pwr, busy, rreq, rowph} = '0;
      mrst_b = 1'b1;
      {paddr, stall, pwdata, addr} = '0;
      creq = '0;
      num_errors = 0;
      checks_done = 0;
      cyc(10);
      rst_b_in <= 1'b1;
      cyc(1);
      apb(0, `SMR_OFS_MEM_CTL, 0);
      check(q, 0);
      apb(0, `SMR_OFS_CARD_CTL, 0);
      check(q, 0);
      apb(0, `SMR_OFS_WAIT_TWO, 0);
      check(q, 32'h3f);
      apb(1, `SMR_OFS_CARD_CTL, 32'hffff);
      apb(0, `SMR_OFS_CARD_CTL, 0);
      check(q, 32'hcfff);
      apb(1, `SMR_OFS_MEM_CTL, 32'h1);
      apb(0, `SMR_OFS_MEM_CTL, 0);
      check(q, 0);
      apb(0, 8'h40, 0);
      check(32'(err), 1);
      // manual reset must leave the card register alone
      apb(1, `SMR_OFS_CARD_CTL, 32'h8abc);
      mrst_b <= 1'b0;
      cyc(3);
      mrst_b <= 1'b1;
      apb(0, `SMR_OFS_CARD_CTL, 0);
      check(q, 32'h8abc);
      // only listed codes; 8Mx16 and 512kx32 assume matching bus width
      addr <= 26'h2b3c5a7;
      rowph <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1, `SMR_OFS_MEM_CTL, {25'h0, mux[i], 3'h0});
         @(negedge clk_in);
         check({18'h0, sdaddr}, {18'h0, 14'(addr >> (st[i] - 1))});
         check(32'(sdaddr[1]), 32'(addr[st[i]]));
         @(posedge clk_in);
      end
      // refresh off: timer request only raises the interval flag
      apb(1, `SMR_OFS_MEM_CTL, 32'h68);
      pulse_req;
      wait_cmd;
      check(32'(n), 20);
      apb(0, `SMR_OFS_STATUS, 0);
      check(q & 32'h4, 32'h4);
      apb(1, `SMR_OFS_STATUS, 32'h4);
      apb(0, `SMR_OFS_STATUS, 0);
      check(q & 32'h4, 0);
      apb(1, `SMR_OFS_MEM_CTL, 32'h6c);
      pulse_req;
      wait_cmd;
      check(32'(n), 2);
      busy <= 1'b1;
      pulse_req;
      wait_cmd;
      check(32'(n), 20);
      busy <= 1'b0;
      wait_cmd;
      check(32'(n >= 2 && n <= 3), 1);
      // self refresh waits out a running bus cycle
      busy <= 1'b1;
      apb(1, `SMR_OFS_MEM_CTL, 32'h6e);
      cyc(3);
      @(negedge clk_in);
      check(32'(selfr), 0);
      @(posedge clk_in);
      busy <= 1'b0;
      cyc(2);
      @(negedge clk_in);
      check(32'(selfr), 1);
      @(posedge clk_in);
      pulse_req;
      wait_cmd;
      check(32'(n), 20);
      apb(1, `SMR_OFS_MEM_CTL, 32'h68);
      // every area 6 code, single read; area 5 high bit kept 0 here
      for (int i = 0; i < 16; i++) begin
         apb(1, `SMR_OFS_CARD_CTL, {16'h0, i[3], 15'h0});
         apb(1, `SMR_OFS_WAIT_TWO, {26'h0, i[2:0], 3'h0});
         card_op(1'b1, 1'b0, 4'h1);
         check(32'(w), 32'((waits[i] + 1) * 2));
         check(32'(s), 2);
         check(32'(h), 1);
         check(32'(dn), 1);
      end
      // area 6 ted 5 teh 3, code 0 write burst of two
      apb(1, `SMR_OFS_CARD_CTL, 32'h0413);
      apb(1, `SMR_OFS_WAIT_TWO, 32'h02);
      card_op(1'b1, 1'b1, 4'h2);
      check(32'(s), 12);
      check(32'(w), 6);
      check(32'(h), 7);
      // area 5 code 10 via its high bit, ted 7, burst of two
      apb(1, `SMR_OFS_CARD_CTL, 32'h48c0);
      card_op(1'b0, 1'b0, 4'h2);
      check(32'(s), 16);
      check(32'(w), 76);
      check(32'(h), 1);
      // slow card stretches code 1, code 0 first beat ignores it
      apb(1, `SMR_OFS_CARD_CTL, 0);
      apb(1, `SMR_OFS_WAIT_TWO, 32'h08);
      stall <= 8'h0a;
      card_op(1'b1, 1'b0, 4'h1);
      check(32'(w > 4 && w <= 14), 1);
      apb(1, `SMR_OFS_WAIT_TWO, 0);
      card_op(1'b1, 1'b0, 4'h1);
      check(32'(w), 2);
      stall <= 8'h00;
      // second power-on reset clears the card register
      apb(1, `SMR_OFS_CARD_CTL, 32'h8abc);
      rst_b_in <= 1'b0;
      cyc(2);
      rst_b_in <= 1'b1;
      cyc(1);
      apb(0, `SMR_OFS_CARD_CTL, 0);
      check(q, 0);
      conclude;
   end

   // hang guard, well past the thousand or so cycles the tests take
   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      conclude;
   end
endmodule
